// ===== core/smie_unit.sv
// Management interrupt entry/exit sequencer
// Assumes core handshakes are synchronous to clk_i; request pin is async
`timescale 1ns/1ps
module smie_unit #(
	parameter logic [31:0] MGMT_BASE = smie_pkg::SMIE_BASE_DEFAULT
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// Pins
	input  wire logic                  sys_mgmt_request_n_i,
	input  wire logic                  bus_hold_grant_i,
	output logic                       sys_mgmt_active_n_o,
	// Core side
	input  wire smie_pkg::smie_core_in_t  core_i,
	output smie_pkg::smie_core_out_t      core_o,
	output logic                       sys_mgmt_mode_o
);

	smie_pkg::smie_regs_t r_reg;
	smie_pkg::smie_regs_t r_next;
	logic                 fall;
	logic                 req_any;
	logic                 can_take;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.co.take_mgmt = 1'b0;
		r_next.co.take_nmi = 1'b0;
		r_next.co.fetch_start = 1'b0;
		r_next.co.resume_done = 1'b0;
		// [RULE23] Three-stage synchroniser
		r_next.sync = {r_reg.sync[1:0], sys_mgmt_request_n_i};
		r_next.sync_prev = r_reg.sync[2];
		// [RULE1] Falling edge detect
		// [RULE2] Third stage low while its previous sample was high
		fall = !r_reg.sync[2] && r_reg.sync_prev;
		req_any = r_reg.edge_seen || fall;
		// [RULE4] Boundary only, no interrupt flag
		// [RULE5] Wait out locked sequences
		can_take = core_i.insn_boundary && !core_i.bus_locked;
		// [RULE8] Hold a single pending request
		if (fall && r_reg.blocked) begin
			r_next.pending = 1'b1;
		end
		if (fall && !r_reg.blocked) begin
			r_next.edge_seen = 1'b1;
		end
		if (r_reg.cnt != 9'h000) begin
			r_next.cnt = r_reg.cnt - 9'h001;
		end
		case (r_reg.state)
			smie_pkg::SMIE_ST_NORMAL: begin
				// [RULE6] Beats NMI
				if (req_any && !r_reg.blocked && can_take) begin
					r_next.co.take_mgmt = 1'b1;
					r_next.edge_seen = 1'b0;
					// [RULE7] Block further requests
					r_next.blocked = 1'b1;
					r_next.cnt = smie_pkg::SMIE_ENTRY_CNT;
					r_next.state = smie_pkg::SMIE_ST_DRAIN;
				end else if (core_i.nmi_request && can_take) begin
					r_next.co.take_nmi = 1'b1;
				end
			end
			smie_pkg::SMIE_ST_DRAIN: begin
				// [RULE14] Assert after writes drain
				if (!core_i.writes_pending) begin
					// [RULE10] Active before saving
					r_next.active_n = 1'b0;
					r_next.sys_mgmt_mode = 1'b1;
					// [RULE20] Save from top downward
					r_next.addr = MGMT_BASE + smie_pkg::SMIE_SAVE_TOP_OFS
						- smie_pkg::SMIE_WORD_BYTES + 32'h1;
					r_next.state = smie_pkg::SMIE_ST_SAVE;
				end
			end
			smie_pkg::SMIE_ST_SAVE: begin
				r_next.co.save_req = 1'b1;
				r_next.co.save_addr = r_reg.addr;
				if (r_reg.co.save_req && core_i.save_ack) begin
					if (r_reg.addr <= MGMT_BASE + smie_pkg::SMIE_SAVE_BOT_OFS) begin
						r_next.co.save_req = 1'b0;
						r_next.state = smie_pkg::SMIE_ST_HANDLE;
					end else begin
						r_next.addr = r_reg.addr - smie_pkg::SMIE_WORD_BYTES;
					end
				end
			end
			smie_pkg::SMIE_ST_HANDLE: begin
				// [RULE21] Entry no faster than minimum
				if (!r_reg.co.pseudo_real && r_reg.cnt == 9'h000) begin
					// [RULE11] Pseudo-real, fetch base plus 8000h
					r_next.co.pseudo_real = 1'b1;
					r_next.co.fetch_start = 1'b1;
					r_next.co.fetch_addr = MGMT_BASE
						+ smie_pkg::SMIE_HANDLER_OFS;
				end
				if (r_reg.co.pseudo_real && core_i.resume_exec) begin
					r_next.cnt = smie_pkg::SMIE_EXIT_CNT;
					r_next.addr = MGMT_BASE + smie_pkg::SMIE_SAVE_BOT_OFS;
					r_next.state = smie_pkg::SMIE_ST_REST;
				end
			end
			smie_pkg::SMIE_ST_REST: begin
				// [RULE12] Reload context first
				r_next.co.restore_req = 1'b1;
				r_next.co.restore_addr = r_reg.addr;
				if (r_reg.co.restore_req && core_i.restore_ack) begin
					if (r_reg.addr >= MGMT_BASE + smie_pkg::SMIE_SAVE_TOP_OFS
						- smie_pkg::SMIE_WORD_BYTES + 32'h1) begin
						// [RULE15] Negate after final read
						r_next.co.restore_req = 1'b0;
						r_next.active_n = 1'b1;
						r_next.co.pseudo_real = 1'b0;
						r_next.state = smie_pkg::SMIE_ST_RETURN;
					end else begin
						r_next.addr = r_reg.addr + smie_pkg::SMIE_WORD_BYTES;
					end
				end
			end
			smie_pkg::SMIE_ST_RETURN: begin
				// [RULE22] Exit no faster than minimum
				if (r_reg.cnt == 9'h000) begin
					r_next.co.resume_done = 1'b1;
					r_next.sys_mgmt_mode = 1'b0;
					r_next.blocked = 1'b0;
					// [RULE8] Pending served before application
					if (r_reg.pending || fall) begin
						r_next.edge_seen = 1'b1;
						r_next.pending = 1'b0;
					end
					r_next.state = smie_pkg::SMIE_ST_NORMAL;
				end
			end
			default: begin
				r_next.state = smie_pkg::SMIE_ST_NORMAL;
			end
		endcase
		// [RULE13] Only I/O or halt restartable
		r_next.co.restart_ok =
			(core_i.restart_op == smie_pkg::SMIE_OP_IO) ||
			(core_i.restart_op == smie_pkg::SMIE_OP_HALT);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r_reg <= '0;
			r_reg.sync <= 3'h7;
			r_reg.sync_prev <= 1'b1;
			r_reg.active_n <= 1'b1;
			r_reg.state <= smie_pkg::SMIE_ST_NORMAL;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// [RULE16] Driven regardless of bus hold
	assign sys_mgmt_active_n_o = r_reg.active_n;
	assign core_o = r_reg.co;
	assign sys_mgmt_mode_o = r_reg.sys_mgmt_mode;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// ----------------------------------------------------------------
	// Recognition
	// ----------------------------------------------------------------
	a_fall_edge: assert property ( // [RULE1]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.take_mgmt
		|-> $past(req_any))
		else $error("take without request edge");

	a_sync_chain: assert property ( // [RULE23]
		@(posedge clk_i) disable iff (!reset_n_i)
		!r_reg.sync[2] && r_reg.sync_prev
		|-> $past(sys_mgmt_request_n_i, 3) == 1'b0)
		else $error("edge not from synchronised pin");

	a_sync_lat: assert property ( // [RULE2]
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(sys_mgmt_request_n_i) ##1 !sys_mgmt_request_n_i[*3]
		##0 r_reg.state == smie_pkg::SMIE_ST_NORMAL && !r_reg.blocked
		|-> ##[0:1] req_any)
		else $error("edge not latched");

	a_single_pulse: assert property ( // [RULE2]
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(sys_mgmt_request_n_i) ##1 $rose(sys_mgmt_request_n_i)
		##0 r_reg.state == smie_pkg::SMIE_ST_NORMAL && !r_reg.blocked
		|-> ##[1:2] req_any)
		else $error("one clock pulse lost");

	a_take_bound: assert property ( // [RULE4]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.take_mgmt
		|-> $past(core_i.insn_boundary))
		else $error("request taken mid instruction");

	a_lock_wait: assert property ( // [RULE5]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.take_mgmt
		|-> !$past(core_i.bus_locked))
		else $error("request taken mid lock");

	a_no_nmi_win: assert property ( // [RULE6]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.take_mgmt
		|-> !core_o.take_nmi)
		else $error("both taken");

	a_nmi_yield: assert property ( // [RULE6]
		@(posedge clk_i) disable iff (!reset_n_i)
		req_any && !r_reg.blocked && can_take
		&& r_reg.state == smie_pkg::SMIE_ST_NORMAL
		|=> core_o.take_mgmt && !core_o.take_nmi)
		else $error("nmi won over request");

	// ----------------------------------------------------------------
	// Masking
	// ----------------------------------------------------------------
	a_take_unblk: assert property ( // [RULE7]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.take_mgmt
		|-> $past(!r_reg.blocked))
		else $error("nested take");

	a_block_hold: assert property ( // [RULE7]
		@(posedge clk_i) disable iff (!reset_n_i)
		r_reg.state != smie_pkg::SMIE_ST_NORMAL
		|-> r_reg.blocked)
		else $error("unblocked in service");

	a_pend_serve: assert property ( // [RULE8]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.resume_done && $past(r_reg.pending)
		|-> r_reg.edge_seen)
		else $error("pending request dropped");

	// ----------------------------------------------------------------
	// Entry
	// ----------------------------------------------------------------
	a_active_drain: assert property ( // [RULE14]
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(sys_mgmt_active_n_o)
		|-> $past(!core_i.writes_pending))
		else $error("active asserted with writes pending");

	a_save_active: assert property ( // [RULE10]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.save_req
		|-> !sys_mgmt_active_n_o)
		else $error("save without active");

	a_first_save: assert property ( // [RULE10]
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(core_o.save_req)
		|-> core_o.save_addr == MGMT_BASE + smie_pkg::SMIE_SAVE_TOP_OFS
		- smie_pkg::SMIE_WORD_BYTES + 32'h1)
		else $error("save not from top");

	a_save_range: assert property ( // [RULE20]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.save_req
		|-> core_o.save_addr >= MGMT_BASE + smie_pkg::SMIE_SAVE_BOT_OFS
		&& core_o.save_addr <= MGMT_BASE + smie_pkg::SMIE_SAVE_TOP_OFS)
		else $error("save outside save area");

	a_cnt_load: assert property ( // [RULE21]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.take_mgmt
		|-> r_reg.cnt == smie_pkg::SMIE_ENTRY_CNT)
		else $error("entry count not loaded");

	a_entry_time: assert property ( // [RULE21]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.fetch_start
		|-> $past(r_reg.cnt) == 9'h000)
		else $error("entry too fast");

	a_fetch_addr: assert property ( // [RULE11]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.fetch_start
		|-> core_o.fetch_addr == MGMT_BASE + 32'h0000_8000
		&& core_o.pseudo_real)
		else $error("bad handler fetch");

	a_hold_drive: assert property ( // [RULE16]
		@(posedge clk_i) disable iff (!reset_n_i)
		bus_hold_grant_i && r_reg.state == smie_pkg::SMIE_ST_HANDLE
		|-> !sys_mgmt_active_n_o)
		else $error("active lost during hold");

	// ----------------------------------------------------------------
	// Exit
	// ----------------------------------------------------------------
	a_rest_active: assert property ( // [RULE15]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.restore_req
		|-> !sys_mgmt_active_n_o)
		else $error("active released before restore");

	a_release: assert property ( // [RULE15]
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(sys_mgmt_active_n_o)
		|-> $past(core_i.restore_ack && r_reg.co.restore_req))
		else $error("active released without read");

	a_resume_act: assert property ( // [RULE12]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.resume_done
		|-> sys_mgmt_active_n_o && !sys_mgmt_mode_o)
		else $error("return before active negated");

	a_exit_load: assert property ( // [RULE22]
		@(posedge clk_i) disable iff (!reset_n_i)
		r_reg.state == smie_pkg::SMIE_ST_REST
		&& $past(r_reg.state) == smie_pkg::SMIE_ST_HANDLE
		|-> r_reg.cnt == smie_pkg::SMIE_EXIT_CNT)
		else $error("exit count not loaded");

	a_exit_time: assert property ( // [RULE22]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.resume_done
		|-> $past(r_reg.cnt) == 9'h000)
		else $error("exit too fast");

	a_restart: assert property ( // [RULE13]
		@(posedge clk_i) disable iff (!reset_n_i)
		core_o.restart_ok
		|-> $past(core_i.restart_op) == smie_pkg::SMIE_OP_IO
		|| $past(core_i.restart_op) == smie_pkg::SMIE_OP_HALT)
		else $error("bad restart");

	c_entry: cover property (@(posedge clk_i) core_o.fetch_start);
	c_exit: cover property (@(posedge clk_i) core_o.resume_done);
	c_pending: cover property (@(posedge clk_i) r_reg.pending && core_o.resume_done);
	c_nmi: cover property (@(posedge clk_i) core_o.take_nmi);
	c_hold: cover property (@(posedge clk_i)
		bus_hold_grant_i && !sys_mgmt_active_n_o);

endmodule : smie_unit

// ===== core/smie_pkg.sv
// Constants and carrier types for the management interrupt entry/exit unit
// Assumes a 40 MHz processor clock and a core that reports instruction
// boundaries, lock state and save/restore progress
// Summary of operation
// [RULE1] Falling request edge is the only entry
// [RULE2] One-clock low pulse latched, long lows fine
// [RULE3] System holds request high four clocks after
// [RULE4] Ignores interrupt flag, taken at instruction boundary
// [RULE5] Locked bus sequences are never broken
// [RULE6] Request beats NMI, accepted during NMI handler
// [RULE7] Further requests blocked until resume completes
// [RULE8] One pending request, served right after resume
// [RULE9] System asserts request three clocks before ready
// [RULE10] Active first, then save context downward
// [RULE11] Pseudo-real mode, fetch at base plus 8000h
// [RULE12] Resume restores, negates active, then returns
// [RULE13] Only I/O and halt may restart
// [RULE14] Active only after writes and buffer drained
// [RULE15] Active held until final restore read done
// [RULE16] Active keeps driven during bus hold
// [RULE17] System flushes cache with request if overlaid
// [RULE18] System decodes 38000h-3FFFFh while active
// [RULE19] System steers other masters to normal memory
// [RULE20] Default save 3FFFFh down to 3FE00h, handler 38000h
// [RULE21] Entry path at least 161 clocks
// [RULE22] Exit path at least 258 clocks
// [RULE23] Request passes two-stage synchroniser first; the code uses a three-stage chain
package smie_pkg;

	// ----------------------------------------------------------------
	// Addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] SMIE_BASE_DEFAULT = 32'h0003_0000;
	localparam logic [31:0] SMIE_HANDLER_OFS  = 32'h0000_8000;
	localparam logic [31:0] SMIE_SAVE_TOP_OFS = 32'h0000_ffff;
	localparam logic [31:0] SMIE_SAVE_BOT_OFS = 32'h0000_fe00;
	localparam logic [31:0] SMIE_WORD_BYTES   = 32'h0000_0004;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SMIE_ENTRY_MIN_CLK = 161;
	localparam int SMIE_EXIT_MIN_CLK  = 258;
	localparam logic [8:0] SMIE_ENTRY_CNT = 9'(SMIE_ENTRY_MIN_CLK);
	localparam logic [8:0] SMIE_EXIT_CNT  = 9'(SMIE_EXIT_MIN_CLK);

	// ----------------------------------------------------------------
	// Opcode classes for restart
	// ----------------------------------------------------------------
	localparam logic [1:0] SMIE_OP_OTHER = 2'h0;
	localparam logic [1:0] SMIE_OP_IO    = 2'h1;
	localparam logic [1:0] SMIE_OP_HALT  = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SMIE_ST_NORMAL = 3'b000,
		SMIE_ST_DRAIN  = 3'b001,
		SMIE_ST_SAVE   = 3'b010,
		SMIE_ST_HANDLE = 3'b011,
		SMIE_ST_REST   = 3'b100,
		SMIE_ST_RETURN = 3'b101
	} smie_state_t;

	typedef struct packed {
		logic insn_boundary;
		logic bus_locked;
		logic nmi_request;
		logic writes_pending;
		logic save_ack;
		logic resume_exec;
		logic restore_ack;
		logic [1:0] restart_op;
	} smie_core_in_t;

	typedef struct packed {
		logic        take_mgmt;
		logic        take_nmi;
		logic        save_req;
		logic [31:0] save_addr;
		logic        restore_req;
		logic [31:0] restore_addr;
		logic        pseudo_real;
		logic        fetch_start;
		logic [31:0] fetch_addr;
		logic        resume_done;
		logic        restart_ok;
	} smie_core_out_t;

	typedef struct packed {
		logic [2:0]     sync;
		logic           sync_prev;
		logic           edge_seen;
		logic           pending;
		logic           blocked;
		smie_state_t    state;
		logic [31:0]    addr;
		logic [8:0]     cnt;
		logic           active_n;
		logic           sys_mgmt_mode;
		smie_core_out_t co;
	} smie_regs_t;

endpackage : smie_pkg

// ===== verification/smie_partner.sv
// Far-side model: system logic and memory controller for mgmt_memory
// Assumes core_o of smie_unit on the same clock; acks one word at a time
`timescale 1ns/1ps
module smie_partner (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_n_i,
	// Pacing
	input  wire logic                     slow_i,
	// Device side
	input  wire logic                     sys_mgmt_active_n_i,
	input  wire smie_pkg::smie_core_out_t core_o_i,
	output logic                          save_ack_o,
	output logic                          restore_ack_o
);
	logic [1:0]  wait_reg;
	logic [31:0] addr;
	logic        hit;

	// ----------------------------------------------------------------
	// Memory decode and acknowledge
	// ----------------------------------------------------------------
	assign addr = core_o_i.save_req ? core_o_i.save_addr
		: core_o_i.restore_addr;
	assign hit = !sys_mgmt_active_n_i && addr >= 32'h0003_8000
		&& addr <= 32'h0003_ffff;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_reg      <= 2'h0;
			save_ack_o    <= 1'b0;
			restore_ack_o <= 1'b0;
		end else begin
			save_ack_o    <= 1'b0;
			restore_ack_o <= 1'b0;
			if (hit && !save_ack_o && !restore_ack_o) begin
				if (wait_reg != 2'h0) begin
					wait_reg <= wait_reg - 2'h1;
				end else begin
					wait_reg      <= {slow_i, 1'b1};
					save_ack_o    <= core_o_i.save_req;
					restore_ack_o <= core_o_i.restore_req;
				end
			end
		end
	end
endmodule : smie_partner

// ===== verification/smie_unit_tb_top.sv
// Self-checking bench for smie_unit with the far-side model
// Assumes the design's embedded assertions guard cycle relations
`timescale 1ns/1ps
module smie_unit_tb_top;
	logic                     clk_i, reset_n_i, req_n, hold, slow;
	logic                     bnd, lck, nmi, wp, rx, s_ack, r_ack, act_n;
	logic [1:0]               op;
	logic [31:0]              last_save, last_rest;
	int                       bad_count, n_checks;
	smie_pkg::smie_core_in_t  core_i;
	smie_pkg::smie_core_out_t core_o;
	logic                     mode;

	// ----------------------------------------------------------------
	// Instances and clock
	// ----------------------------------------------------------------
	assign core_i = smie_pkg::smie_core_in_t'{insn_boundary: bnd,
		bus_locked: lck, nmi_request: nmi, writes_pending: wp,
		save_ack: s_ack, resume_exec: rx, restore_ack: r_ack,
		restart_op: op};
	smie_unit i_smie_unit (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.sys_mgmt_request_n_i(req_n), .bus_hold_grant_i(hold),
		.sys_mgmt_active_n_o(act_n), .core_i(core_i), .core_o(core_o),
		.sys_mgmt_mode_o(mode));
	smie_partner i_smie_partner (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.slow_i(slow), .sys_mgmt_active_n_i(act_n), .core_o_i(core_o),
		.save_ack_o(s_ack), .restore_ack_o(r_ack));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (s_ack) last_save <= core_o.save_addr;
		if (r_ack) last_rest <= core_o.restore_addr;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, m, seen, exp);
		end
	endtask : check
	function automatic logic sig(input int s);
		case (s)
			0: return core_o.take_mgmt;
			1: return core_o.fetch_start;
			2: return core_o.resume_done;
			default: return core_o.take_nmi;
		endcase
	endfunction : sig
	task automatic wait_sig(input int s, lim, output int n);
		n = 0;
		#1;
		while (sig(s) !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= lim) begin
			bad_count++;
			$display("[FAIL] %0t wait %0d ran out", $time, s);
			final_report();
		end
	endtask : wait_sig
	task automatic pulse_req(input int low);
		@(posedge clk_i) req_n <= 1'b0;
		repeat (low) @(posedge clk_i);
		req_n <= 1'b1;
	endtask : pulse_req
	task automatic enter(input logic skip);
		int n;
		if (!skip) pulse_req(1);
		wait_sig(0, 40, n);
		check(32'(core_o.take_nmi), 0, "nmi beat request");
		repeat (5) begin
			@(posedge clk_i);
			#1 check(32'(act_n), 1, "active before drain");
		end
		@(posedge clk_i) wp <= 1'b0;
		nmi <= 1'b0;
		hold <= 1'b1;
		wait_sig(1, 3000, n);
		check(32'(n >= 155), 1, "entry too fast");
		check(core_o.fetch_addr, 32'h0003_8000, "handler addr");
		check(last_save, 32'h0003_fe00, "last save addr");
		check({core_o.pseudo_real, mode, act_n}, 3'b110, "mode");
		@(posedge clk_i) wp <= 1'b1;
	endtask : enter
	task automatic leave(input logic [1:0] o);
		int n;
		@(posedge clk_i) op <= o;
		rx <= 1'b1;
		hold <= 1'b0;
		@(posedge clk_i) rx <= 1'b0;
		wait_sig(2, 3000, n);
		check(32'(n >= 257), 1, "exit too fast");
		check(last_rest, 32'h0003_fffc, "last restore");
		check({act_n, mode}, 2'b10, "exit state");
		check(32'(core_o.restart_ok), 32'(o != 2'h0), "restart");
	endtask : leave

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_codes();
		for (int i = 0; i < 3; i++) begin
			slow <= i[0];
			enter(1'b0);
			leave(2'(i));
		end
	endtask : sc_codes
	task automatic sc_lock_nmi();
		@(posedge clk_i) lck <= 1'b1;
		nmi <= 1'b1;
		pulse_req(3);
		repeat (20) begin
			@(posedge clk_i);
			#1 check(32'(core_o.take_mgmt), 0, "took in lock");
		end
		@(posedge clk_i) lck <= 1'b0;
		bnd <= 1'b0;
		repeat (10) begin
			@(posedge clk_i);
			#1 check(32'(core_o.take_mgmt), 0, "took mid insn");
		end
		@(posedge clk_i) bnd <= 1'b1;
		enter(1'b1);
		leave(smie_pkg::SMIE_OP_HALT);
	endtask : sc_lock_nmi
	task automatic sc_nest();
		int n;
		enter(1'b0);
		pulse_req(1);
		repeat (5) @(posedge clk_i);
		pulse_req(2);
		leave(smie_pkg::SMIE_OP_IO);
		wait_sig(0, 4, n);
		enter(1'b1);
		leave(smie_pkg::SMIE_OP_IO);
		repeat (200) begin
			@(posedge clk_i);
			#1 check(32'(core_o.take_mgmt), 0, "extra take");
		end
	endtask : sc_nest
	task automatic sc_nmi();
		int n;
		@(posedge clk_i) nmi <= 1'b1;
		wait_sig(3, 10, n);
		check(32'(core_o.take_mgmt), 0, "spurious take");
		@(posedge clk_i) nmi <= 1'b0;
	endtask : sc_nmi

	initial begin
		{reset_n_i, hold, slow, bnd, lck, nmi, rx, op} = '0;
		{req_n, wp} = 2'b11;
		{bad_count, n_checks} = '0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i) bnd <= 1'b1;
		repeat (5) @(posedge clk_i);
		sc_codes();
		sc_lock_nmi();
		sc_nest();
		sc_nmi();
		final_report();
	end
endmodule : smie_unit_tb_top
